// ---- core/hdlc_chan_regs.sv ----
// Channel mode, frame sync policy and interrupt registers over AXI4-Lite
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module hdlc_chan_regs
   import hdlc_regs_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              srst_in,
   input  wire logic              link_clk_in,
   input  wire logic              frame_sync_in,
   input  wire logic [NUM_CH-1:0] rx_block_full_in,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [DATA_W-1:0] s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic [DATA_W-1:0]      s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   output logic                   hdlc_enable_out,
   output logic [NUM_CH-1:0]      channel_active_out
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic              awready_q;
   logic              wready_q;
   logic              aw_hold_q;
   logic              w_hold_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [REG_W-1:0]  w_data_q;
   logic              w_strb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0]        rresp_q;
   logic              test_q;
   logic [1:0]        split_q;
   logic [NUM_CH-1:0] policy_q;
   logic [NUM_CH-1:0] irq_q;
   logic [NUM_CH-1:0] full_q;
   logic [NUM_CH-1:0] over_q;
   logic              hdlc_enable_q;
   logic [NUM_CH-1:0] channel_active_q;

   // ---------------------------------------------------------------
   // Link domain and crossing
   // ---------------------------------------------------------------
   link_evt_t         evt_tog;
   link_evt_t         evt_pulse;

   link_events u_link (
      .link_clk_in      (link_clk_in),
      .srst_in          (srst_in),
      .frame_sync_in    (frame_sync_in),
      .rx_block_full_in (rx_block_full_in),
      .enable_in        (hdlc_enable_q),
      .active_in        (channel_active_q),
      .policy_in        (policy_q),
      .evt_tog_out      (evt_tog)
   );

   toggle_rx #(
      .WIDTH (2 * NUM_CH)
   ) u_evt_rx (
      .clk_in    (ref_clk_in),
      .srst_in   (srst_in),
      .tog_in    (evt_tog),
      .pulse_out (evt_pulse)
   );

   // ---------------------------------------------------------------
   // Write path decode
   // ---------------------------------------------------------------
   wire aw_fire    = s_axi_awvalid_in & awready_q;
   wire w_fire     = s_axi_wvalid_in & wready_q;
   wire wr_go      = aw_hold_q & w_hold_q & ~bvalid_q;
   wire wr_test    = (aw_addr_q == ADDR_TEST);
   wire wr_split   = (aw_addr_q == ADDR_SPLIT);
   wire wr_policy  = (aw_addr_q == ADDR_POLICY);
   wire wr_ok      = wr_test | wr_split | wr_policy;
   wire wr_lane    = wr_go & w_strb_q;
   wire test_we    = wr_lane & wr_test;
   wire split_we   = wr_lane & wr_split;
   wire policy_we  = wr_lane & wr_policy;

   // ---------------------------------------------------------------
   // Read path decode
   // ---------------------------------------------------------------
   wire ar_fire    = s_axi_arvalid_in & arready_q;
   wire r_fire     = rvalid_q & s_axi_rready_in;
   wire rd_test    = (s_axi_araddr_in == ADDR_TEST);
   wire rd_split   = (s_axi_araddr_in == ADDR_SPLIT);
   wire rd_policy  = (s_axi_araddr_in == ADDR_POLICY);
   wire rd_irq     = (s_axi_araddr_in == ADDR_IRQ);
   wire [NUM_CH-1:0] rd_stat_sel;
   logic [REG_W-1:0] stat_word [NUM_CH];

   for (genvar i = 0; i < NUM_CH; i++) begin : g_stat
      assign rd_stat_sel[i] = (s_axi_araddr_in ==
                               ADDR_STAT0 + ADDR_W'(i) * STAT_STRIDE);
      // Flags not produced by this block read as their idle value
      assign stat_word[i]   = {8'h00, 1'b0, over_q[i], full_q[i],
                               STAT_FILL_DEFAULT};
   end

   logic [REG_W-1:0] stat_rd;
   always_comb begin
      stat_rd = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         stat_rd = stat_rd | (rd_stat_sel[i] ? stat_word[i] : '0);
      end
   end

   // The write-only test register reads back as zero
   wire rd_ok = rd_test | rd_split | rd_policy | rd_irq | (|rd_stat_sel);
   wire [REG_W-1:0] rd_word =
      rd_split  ? {14'h0000, split_q}  :
      rd_policy ? {12'h000, policy_q}  :
      rd_irq    ? {12'h000, irq_q}     :
      stat_rd;

   // ---------------------------------------------------------------
   // Channel events
   // ---------------------------------------------------------------
   // Events still in flight when a channel is switched off are dropped
   wire [NUM_CH-1:0] ev_gate  = channel_active_q & {NUM_CH{hdlc_enable_q}};
   wire [NUM_CH-1:0] full_evt = evt_pulse.full & ev_gate;
   wire [NUM_CH-1:0] rx_evt   = evt_pulse.rx_irq & ev_gate;
   wire [NUM_CH-1:0] irq_set  = full_evt | rx_evt;
   wire [NUM_CH-1:0] stat_clr = {NUM_CH{ar_fire}} & rd_stat_sel;
   // Set wins over a clear in the same cycle for full and irq; a clear blocks the over set
   wire [NUM_CH-1:0] full_d   = (full_q & ~stat_clr) | full_evt;
   wire [NUM_CH-1:0] over_d   = (over_q & ~stat_clr) |
                                (full_evt & full_q & ~stat_clr);
   wire [NUM_CH-1:0] irq_d    = (irq_q & ~stat_clr) | irq_set;
   wire [NUM_CH-1:0] split_mask =
      (split_q == SPLIT_ONE)  ? MASK_ONE  :
      (split_q == SPLIT_TWO)  ? MASK_TWO  :
      (split_q == SPLIT_FOUR) ? MASK_FOUR : MASK_NONE;

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
            awready_q <= 1'b0;
         end
         if (w_fire) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata_in[REG_W-1:0];
            w_strb_q <= s_axi_wstrb_in[0];
            wready_q <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready_in) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {16'h0000, rd_word};
            rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (r_fire) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control and status registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         test_q           <= TEST_RST;
         split_q          <= SPLIT_RST;
         policy_q         <= POLICY_RST;
         irq_q            <= IRQ_RST;
         full_q           <= '0;
         over_q           <= '0;
         hdlc_enable_q    <= 1'b0;
         channel_active_q <= '0;
      end else begin
         if (test_we)   test_q   <= w_data_q[TEST_BIT];
         if (split_we)  split_q  <= w_data_q[SPLIT_LSB +: 2];
         if (policy_we) policy_q <= w_data_q[NUM_CH-1:0];
         irq_q            <= irq_d;
         full_q           <= full_d;
         over_q           <= over_d;
         // Unit stays in test until software clears the test bit
         hdlc_enable_q    <= ~test_q;
         channel_active_q <= split_mask;
      end
   end

   assign s_axi_awready_out  = awready_q;
   assign s_axi_wready_out   = wready_q;
   assign s_axi_bvalid_out   = bvalid_q;
   assign s_axi_bresp_out    = bresp_q;
   assign s_axi_arready_out  = arready_q;
   assign s_axi_rvalid_out   = rvalid_q;
   assign s_axi_rdata_out    = rdata_q;
   assign s_axi_rresp_out    = rresp_q;
   assign hdlc_enable_out    = hdlc_enable_q;
   assign channel_active_out = channel_active_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   sequence stat_read_s;
      ar_fire && (|rd_stat_sel);
   endsequence

   test_reset_a:
      assert property ($past(srst_in) |-> test_q && !hdlc_enable_q)
      else $error("test bit not set after reset");

   test_blocks_a:
      assert property (test_q [*3] |-> ((irq_q & ~$past(irq_q)) == 4'h0))
      else $error("interrupt raised while in test operation");

   split_one_a:
      assert property (split_q == SPLIT_ONE |=> channel_active_q == 4'h1)
      else $error("split 00 must enable channel 0 only");

   split_two_a:
      assert property (split_q == SPLIT_TWO |=> channel_active_q == 4'h9)
      else $error("split 01 must enable channels 0 and 3");

   split_four_a:
      assert property (split_q == SPLIT_FOUR |=> channel_active_q == 4'hF)
      else $error("split 10 must enable all channels");

   irq_cause_a:
      assert property (|(irq_q & ~$past(irq_q)) |-> |$past(irq_set))
      else $error("indication flag set without a channel event");

   policy_reset_a:
      assert property ($past(srst_in) |-> policy_q == 4'h0 && irq_q == 4'h0)
      else $error("policy or indication not zero after reset");

   full_set_a:
      assert property (|full_evt |=>
         ((full_q & irq_q & $past(full_evt)) == $past(full_evt)))
      else $error("buffer-full event not recorded");

   stat_clear_a:
      assert property (stat_read_s |=>
         ((full_q | over_q) & $past(rd_stat_sel) & ~$past(full_evt)) == 4'h0)
      else $error("status read did not restore defaults");

   irq_clear_a:
      assert property (stat_read_s |=>
         (irq_q & $past(rd_stat_sel) & ~$past(irq_set)) == 4'h0)
      else $error("indication flag not cleared by status read");
endmodule
`default_nettype wire

// ---- core/hdlc_regs_pkg.sv ----
// Constants and types shared by the HDLC channel mode and interrupt registers
package hdlc_regs_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NUM_CH = 4;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;

   // ---------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_TEST   = 16'hD0C0;
   localparam logic [15:0] IDX_SPLIT  = 16'hD0C1;
   localparam logic [15:0] IDX_STAT0  = 16'hD0C2;
   localparam logic [15:0] IDX_POLICY = 16'hD0D3;
   localparam logic [15:0] IDX_IRQ    = 16'hD0D4;

   localparam logic [ADDR_W-1:0] ADDR_TEST   = {2'h0, IDX_TEST, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_SPLIT  = {2'h0, IDX_SPLIT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STAT0  = {2'h0, IDX_STAT0, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_POLICY = {2'h0, IDX_POLICY, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ    = {2'h0, IDX_IRQ, 2'h0};
   localparam logic [ADDR_W-1:0] STAT_STRIDE = 20'h00004;

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic        TEST_RST     = 1'h1;
   localparam logic [1:0]  SPLIT_RST    = 2'h0;
   localparam logic [3:0]  POLICY_RST   = 4'h0;
   localparam logic [3:0]  IRQ_RST      = 4'h0;
   localparam logic [4:0]  STAT_FILL_DEFAULT = 5'h1E;
   localparam int          TEST_BIT     = 0;
   localparam int          SPLIT_LSB    = 0;
   localparam int          STAT_FULL_BIT = 5;
   localparam int          STAT_OVER_BIT = 6;

   // ---------------------------------------------------------------
   // Channel split codes and the channels each one enables
   // ---------------------------------------------------------------
   localparam logic [1:0] SPLIT_ONE  = 2'h0;
   localparam logic [1:0] SPLIT_TWO  = 2'h1;
   localparam logic [1:0] SPLIT_FOUR = 2'h2;
   localparam logic [3:0] MASK_ONE   = 4'h1;
   localparam logic [3:0] MASK_TWO   = 4'h9;
   localparam logic [3:0] MASK_FOUR  = 4'hF;
   localparam logic [3:0] MASK_NONE  = 4'h0;

   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Per-channel event toggles carried from the link domain
   typedef struct packed {
      logic [NUM_CH-1:0] rx_irq;
      logic [NUM_CH-1:0] full;
   } link_evt_t;

endpackage

// ---- core/toggle_rx.sv ----
// Receiving half of a toggle crossing: turns toggles into one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module toggle_rx #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   input  wire logic [WIDTH-1:0] tog_in,
   output logic      [WIDTH-1:0] pulse_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] pulse_q;

   // Both sides reset to zero toggles, so no pulse leaks out of reset
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         pulse_q <= '0;
      end else begin
         s1_q    <= tog_in;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         pulse_q <= s2_q ^ s3_q;
      end
   end

   assign pulse_out = pulse_q;
endmodule
`default_nettype wire

// ---- core/link_events.sv ----
// Link-clock logic: frame sync edge, buffer-full tracking, event toggles
`timescale 1ns/1ps
`default_nettype none
module link_events
   import hdlc_regs_pkg::*;
(
   input  wire logic              link_clk_in,
   input  wire logic              srst_in,
   input  wire logic              frame_sync_in,
   input  wire logic [NUM_CH-1:0] rx_block_full_in,
   input  wire logic              enable_in,
   input  wire logic [NUM_CH-1:0] active_in,
   input  wire logic [NUM_CH-1:0] policy_in,
   output link_evt_t              evt_tog_out
);
   localparam int LW = 3 + 2 * NUM_CH;

   logic [LW-1:0]     s1_q;
   logic [LW-1:0]     s2_q;
   logic              fs_d_q;
   logic [NUM_CH-1:0] seen_q;
   link_evt_t         tog_q;

   // ---------------------------------------------------------------
   // Level synchronisers from the register domain and the pin
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk_in) begin
      s1_q <= {srst_in, frame_sync_in, enable_in, active_in, policy_in};
      s2_q <= s1_q;
   end

   wire              lrst      = s2_q[LW-1];
   wire              fs_s      = s2_q[LW-2];
   wire              en_s      = s2_q[LW-3];
   wire [NUM_CH-1:0] act_s     = s2_q[2*NUM_CH-1:NUM_CH];
   wire [NUM_CH-1:0] pol_s     = s2_q[NUM_CH-1:0];
   wire              fs_rise   = fs_s & ~fs_d_q;
   wire [NUM_CH-1:0] gate      = {NUM_CH{en_s}} & act_s;
   wire [NUM_CH-1:0] full_now  = rx_block_full_in & gate;
   // A full on the edge cycle belongs to the frame that starts there
   wire [NUM_CH-1:0] rx_fire   = {NUM_CH{fs_rise}} & gate &
                                 (pol_s | ~seen_q);
   wire [NUM_CH-1:0] seen_d    = fs_rise ? full_now : (seen_q | full_now);

   // ---------------------------------------------------------------
   // Event state
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk_in) begin
      if (lrst) begin
         fs_d_q <= 1'b0;
         seen_q <= '0;
         tog_q  <= '0;
      end else begin
         fs_d_q       <= fs_s;
         seen_q       <= seen_d;
         tog_q.full   <= tog_q.full ^ full_now;
         tog_q.rx_irq <= tog_q.rx_irq ^ rx_fire;
      end
   end

   assign evt_tog_out = tog_q;

   sequence fs_edge_s;
      fs_s && !fs_d_q;
   endsequence

   rx_skip_full_a:
      assert property (@(posedge link_clk_in) disable iff (lrst)
         fs_edge_s |=> (((tog_q.rx_irq ^ $past(tog_q.rx_irq)) &
                         ~$past(pol_s)) == $past(gate & ~pol_s & ~seen_q)))
      else $error("receiver interrupt wrong with policy bit clear");

   rx_always_a:
      assert property (@(posedge link_clk_in) disable iff (lrst)
         fs_edge_s |=> (((tog_q.rx_irq ^ $past(tog_q.rx_irq)) &
                         $past(pol_s)) == $past(gate & pol_s)))
      else $error("receiver interrupt missing at frame sync edge");
endmodule
`default_nettype wire

// ---- test/line_partner.sv ----
// Far-side serial line model: link clock, frame sync and block-full pulses
`timescale 1ns/1ps
`default_nettype none
module line_partner
   import hdlc_regs_pkg::*;
(
   output logic              link_clk_out,
   output logic              frame_sync_out,
   output logic [NUM_CH-1:0] full_out
);
   // A TDM bit clock runs on between frames; offset keeps it off ref edges
   initial begin
      link_clk_out = 1'b0;
      #3.7;
      forever #32 link_clk_out = ~link_clk_out;
   end

   initial begin
      frame_sync_out = 1'b0;
      full_out       = '0;
   end

   // Long enough for the synchroniser and the crossing to settle
   task automatic settle();
      repeat (10) @(posedge link_clk_out);
   endtask

   task automatic full_pulse(input int c);
      @(posedge link_clk_out);
      full_out[c] <= 1'b1;
      @(posedge link_clk_out);
      full_out <= '0;
      settle();
   endtask

   task automatic frame_edge();
      @(posedge link_clk_out);
      frame_sync_out <= 1'b1;
      repeat (4) @(posedge link_clk_out);
      frame_sync_out <= 1'b0;
      settle();
   endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the HDLC channel mode and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module tb
   import hdlc_regs_pkg::*;
;
   localparam logic [15:0] ST_DEF  = {11'h000, STAT_FILL_DEFAULT};
   localparam logic [15:0] ST_FULL = ST_DEF | (16'h0001 << STAT_FULL_BIT);
   localparam logic [15:0] ST_OVER = ST_FULL | (16'h0001 << STAT_OVER_BIT);
   logic              clk, srst, link_clk, fsync;
   logic [NUM_CH-1:0] full, active;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [1:0]        bresp, rresp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, hdlc_en;
   logic [3:0]        pol;
   logic [3:0]        masks [4] = '{MASK_ONE, MASK_TWO, MASK_FOUR, MASK_NONE};
   logic [1:0]        exp_b [$];
   logic [33:0]       exp_r [$];
   int                error_cnt, num_checks, ch;

   hdlc_chan_regs dut (
      .ref_clk_in(clk), .srst_in(srst), .link_clk_in(link_clk),
      .frame_sync_in(fsync), .rx_block_full_in(full),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .hdlc_enable_out(hdlc_en),
      .channel_active_out(active));

   line_partner p (.link_clk_out(link_clk), .frame_sync_out(fsync),
      .full_out(full));

   // ---------------------------------------------------------------
   // Bus master and result checking
   // ---------------------------------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   always @(posedge clk) begin
      if (bvalid === 1'b1 && bready === 1'b1)
         chk({32'h0, bresp}, {32'h0, exp_b.pop_front()});
      if (rvalid === 1'b1 && rready === 1'b1)
         chk({rresp, rdata}, exp_r.pop_front());
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                     input logic [1:0] r);
      exp_b.push_back(r);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                     input logic [1:0] r);
      exp_r.push_back({r, 16'h0000, d});
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask

   function automatic logic [ADDR_W-1:0] st(input int c);
      return ADDR_STAT0 + ADDR_W'(c * 4);
   endfunction

   // Reading every status also drops every indication flag
   task automatic clr();
      for (int c = 0; c < NUM_CH; c++) rd(st(c), ST_DEF, RESP_OKAY);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      #100us;
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      final_report();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      srst = 1'b1;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      ch = $urandom(32'h9EF8);
      // Longer than 24 cycles so the link domain sees three edges
      repeat (25) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({33'h0, hdlc_en}, 34'h0);
      chk({30'h0, active}, {30'h0, MASK_ONE});
      rd(ADDR_SPLIT, 16'h0000, RESP_OKAY);
      rd(ADDR_POLICY, 16'h0000, RESP_OKAY);
      p.full_pulse(0);
      rd(ADDR_IRQ, 16'h0000, RESP_OKAY);
      rd(ADDR_TEST, 16'h0000, RESP_OKAY);
      rd(st(0), ST_DEF, RESP_OKAY);
      $display("test reset done");
      wr(ADDR_TEST, 16'h0000, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({33'h0, hdlc_en}, 34'h1);
      wr(ADDR_TEST, 16'h0001, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({33'h0, hdlc_en}, 34'h0);
      wr(ADDR_TEST, 16'h0000, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SPLIT, 16'(i), RESP_OKAY);
         rd(ADDR_SPLIT, 16'(i), RESP_OKAY);
         repeat (2) @(posedge clk);
         chk({30'h0, active}, {30'h0, masks[i]});
      end
      wr(ADDR_IRQ, 16'h000F, RESP_SLVERR);
      rd(20'h00000, 16'h0000, RESP_SLVERR);
      rd(ADDR_SPLIT + 20'h00001, 16'h0000, RESP_SLVERR);
      $display("test mode done");
      wr(ADDR_SPLIT, {14'h0, SPLIT_TWO}, RESP_OKAY);
      p.full_pulse(1);
      rd(ADDR_IRQ, 16'h0000, RESP_OKAY);
      p.full_pulse(3);
      rd(ADDR_IRQ, 16'h0008, RESP_OKAY);
      rd(st(3), ST_FULL, RESP_OKAY);
      rd(ADDR_IRQ, 16'h0000, RESP_OKAY);
      rd(st(3), ST_DEF, RESP_OKAY);
      wr(ADDR_SPLIT, {14'h0, SPLIT_FOUR}, RESP_OKAY);
      p.frame_edge();
      rd(ADDR_IRQ, {12'h000, MASK_FOUR & ~4'h8}, RESP_OKAY);
      for (int j = 0; j < 4; j++) begin
         pol = (j == 0) ? 4'h0 : 4'($urandom_range(15, 0));
         ch = $urandom_range(3, 0);
         wr(ADDR_POLICY, {12'h000, pol}, RESP_OKAY);
         rd(ADDR_POLICY, {12'h000, pol}, RESP_OKAY);
         clr();
         p.full_pulse(ch);
         rd(st(ch), ST_FULL, RESP_OKAY);
         p.frame_edge();
         rd(ADDR_IRQ, {12'h000, pol | ~(4'h1 << ch)},
            RESP_OKAY);
      end
      clr();
      p.full_pulse(2);
      p.full_pulse(2);
      rd(st(2), ST_OVER, RESP_OKAY);
      rd(st(2), ST_DEF, RESP_OKAY);
      $display("test events done");
      final_report();
   end
endmodule
`default_nettype wire
